/* rssg_pkg.sv */
package rssg_pkg;

	// Timing base
	localparam int CLK_MHZ = 125;
	localparam int DEGL_NS = 10000;
	localparam int DEGL_CYC = (DEGL_NS * CLK_MHZ + 999) / 1000;
	localparam int PG_DELAY_NS = 1000;
	localparam int PG_CYC = (PG_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int INIT_NS = 10000000;
	localparam int INIT_CYC = INIT_NS / 1000 * CLK_MHZ / 1000;
	localparam logic [10:0] RC_TERM = 11'(DEGL_CYC);
	localparam logic [7:0] PG_TERM = 8'(PG_CYC);

	// Switching period and sync qualification in clock cycles; phase angles in degrees
	localparam int SW_PER = 156;
	localparam int SYNC_MIN_HI = 8;
	localparam int SYNC_PER_MIN = 125;
	localparam int SYNC_PER_MAX = 187;
	localparam int FULL_DEG = 360;
	localparam int SEP_INT = 180;
	localparam int SEP_EXT = 120;

	// Strap decoding
	localparam int VOUT_BASE_MV = 500;
	localparam int VOUT_STEP_MV = 10;
	localparam int VOUT_MAX_MV = 5000;
	localparam int SS_STEP_US = 500;
	localparam logic [2:0] STRAP_NOCLK = 3'h5;
	localparam logic [2:0] STRAP_BAD = 3'h7;
	localparam logic [8:0] PH_BASE [0:7] = '{9'h082, 9'h064, 9'h0A0, 9'h055, 9'h0AF, 9'h028, 9'h028, 9'h028};

	// Synchronised pin vector layout
	localparam int P_RECALL = 0;
	localparam int P_SYNC = 1;
	localparam int P_GND = 2;
	localparam int P_SENSE = 3;
	localparam int P_LOW = 4;
	localparam int P_EN = 5;
	localparam int P_ADDR = 6;
	localparam int P_EXT = 7;
	localparam int PIN_W = 23;

	// Register byte offsets
	localparam logic [7:0] ADR_OPER = 8'h00;
	localparam logic [7:0] ADR_VOUT = 8'h04;
	localparam logic [7:0] ADR_TON = 8'h08;
	localparam logic [7:0] ADR_GAIN = 8'h0C;
	localparam logic [7:0] ADR_STS = 8'h10;
	localparam logic [7:0] ADR_MASK = 8'h14;
	localparam logic [7:0] ADR_STATE = 8'h18;

	// Status bit positions
	localparam int SB_RECALL = 0;
	localparam int SB_PG = 1;
	localparam int SB_SYNC = 2;
	localparam int SB_STRAP = 3;
	localparam int SB_SENSE = 4;
	localparam int SB_CML = 5;

	// Operation codes and reset values
	localparam logic [7:0] OPER_OFF = 8'h00;
	localparam logic [7:0] OPER_SOFT = 8'h40;
	localparam logic [7:0] OPER_ON = 8'h80;
	localparam logic [7:0] OPER_RST = 8'h80;
	localparam logic [7:0] GAIN_RST = 8'h04;

	// Supervisor states
	typedef enum logic [2:0] {ST_INIT, ST_CHECK, ST_OFF, ST_RAMP, ST_REG, ST_FAULT} rssg_st_t;

endpackage : rssg_pkg

/* rssg_top.sv */
`timescale 1ns/1ps
module rssg_top #(
	parameter int INIT_CYCLES = rssg_pkg::INIT_CYC
) (
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Pins and straps
	input wire logic recall_n,
	input wire logic sync_in,
	input wire logic sync_in_grounded,
	input wire logic remote_sense_pos_open,
	input wire logic vout_below_pg,
	input wire logic enable_pin,
	input wire logic addr_strap_bad,
	input wire logic ext_stage_present,
	input wire logic [7:0] vout_config_strap,
	input wire logic [3:0] softstart_config_strap,
	input wire logic [2:0] sync_strap,
	// Regulator controls
	output logic sync_out,
	output logic power_ok_output_o,
	output logic power_ok_output_oe_n,
	output logic switching_enable,
	output logic [15:0] setpoint_mv,
	output logic switch_node_one,
	output logic switch_node_two,
	output logic switch_node_three,
	// Current rebalance
	input wire logic [15:0] common_ctrl,
	input wire logic [11:0] phase_current_one,
	input wire logic [11:0] phase_current_two,
	input wire logic [11:0] phase_current_three,
	output logic [15:0] phase_current_rebalance_one,
	output logic [15:0] phase_current_rebalance_two,
	output logic [15:0] phase_current_rebalance_three,
	// Interrupt
	output logic irq
);
	import rssg_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// All state in one record
	typedef struct packed {
		logic [PIN_W-1:0] meta; // First sync stage
		logic [PIN_W-1:0] sy; // Second sync stage
		rssg_st_t st;
		logic [20:0] init_cnt;
		logic [15:0] vstrap; // Strap voltage, mV
		logic [15:0] vcmd; // Target setpoint, mV
		logic [15:0] ton; // Ramp time, us
		logic [7:0] oper;
		logic [7:0] gain;
		logic [15:0] setp; // Ramping setpoint
		logic [23:0] step_cnt;
		logic [10:0] rc_cnt;
		logic rc_lo; // Qualified recall low
		logic [5:0] sts;
		logic [5:0] mask;
		logic irq;
		logic [7:0] pg_cnt;
		logic pg_rel; // Power ok released high
		logic pg_o;
		logic sw_en;
		logic [2:0] ph_strap;
		logic ext;
		logic master;
		logic [9:0] hi_cnt;
		logic [9:0] per_cnt;
		logic sy_prev;
		logic sync_ok;
		logic [7:0] ph_cnt;
		logic sync_out;
		logic [2:0] sn;
		logic [2:0][15:0] ctrl;
		logic a_wr;
		logic [7:0] a_addr;
		logic [31:0] rdata;
		logic rdy;
		logic resp;
	} rssg_state_t;

	localparam rssg_state_t S_RST = '{st: ST_INIT, oper: OPER_RST, gain: GAIN_RST,
		ph_strap: STRAP_NOCLK, rdy: 1'b1, default: '0};

	rssg_state_t s;
	rssg_state_t next_s;
	logic [5:0] sts_set; // Hardware events this cycle
	logic [5:0] w1c; // Software clears this cycle
	logic want_on;
	logic oper_ok;
	logic rise;
	logic fall;
	logic acc;
	logic [23:0] step_lim;
	logic [15:0] vs;
	logic [2:0][7:0] pos; // Phase start counts
	logic [2:0][15:0] phase_current_rebalance; // Rebalanced controls
	logic [2:0][11:0] iph;
	logic signed [13:0] isum;
	logic signed [13:0] iavg;

	////////////////////////////////////////////////////////////////////////
	// Per-phase position and rebalance
	assign iph = {phase_current_three, phase_current_two, phase_current_one};
	// Third phase joins the average only with the external stage
	assign isum = 14'($signed(iph[0])) + 14'($signed(iph[1])) + (s.ext ? 14'($signed(iph[2])) : 14'sd0);
	assign iavg = s.ext ? isum / 14'sd3 : isum / 14'sd2;

	for (genvar i = 0; i < 3; i++)
	begin : g_ph
		logic [9:0] deg;
		logic [9:0] degw;
		logic signed [13:0] dev;
		logic signed [23:0] prod;
		// Spacing 180 alone, 120 with external stage
		assign deg = 10'(PH_BASE[s.ph_strap]) + 10'(i) * (s.ext ? 10'(SEP_EXT) : 10'(SEP_INT));
		assign degw = (deg >= 10'(FULL_DEG)) ? deg - 10'(FULL_DEG) : deg;
		assign pos[i] = 8'((18'(degw) * 18'(SW_PER)) / 18'(FULL_DEG));
		// Result wraps at 16 bits; loop gains keep it in range
		assign dev = 14'($signed(iph[i])) - iavg;
		assign prod = $signed({1'b0, s.gain}) * dev;
		assign phase_current_rebalance[i] = 16'($signed(common_ctrl) - prod);
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb
	begin
		next_s = s;
		sts_set = '0;
		w1c = '0;
		vs = 16'(VOUT_BASE_MV) + 16'(s.sy[15:8]) * 16'(VOUT_STEP_MV);
		want_on = s.oper[7] & s.sy[P_EN];
		oper_ok = hwdata[7:0] inside {OPER_OFF, OPER_SOFT, OPER_ON};
		rise = s.sy[P_SYNC] & ~s.sy_prev;
		fall = ~s.sy[P_SYNC] & s.sy_prev;
		acc = hsel & hready & htrans[1];
		// Guard against divide by zero and zero-length steps
		step_lim = (s.vcmd == 16'h0000) ? 24'h00_0001 : (24'(s.ton) * 24'(CLK_MHZ)) / 24'(s.vcmd);
		// Pins and straps cross in through two stages
		next_s.meta = {sync_strap, softstart_config_strap, vout_config_strap, ext_stage_present,
			addr_strap_bad, enable_pin, vout_below_pg, remote_sense_pos_open, sync_in_grounded,
			sync_in, recall_n};
		next_s.sy = s.meta;
		next_s.rdy = 1'b1;
		next_s.resp = 1'b0;
		next_s.pg_o = 1'b0;

		// Register writes in the data phase
		if (s.a_wr)
		begin
			case (s.a_addr)
				ADR_OPER:
				begin
					// Only plain on/off codes pass while recalled
					if (!s.rc_lo || oper_ok)
						next_s.oper = hwdata[7:0];
				end
				ADR_VOUT:
				begin
					if (s.rc_lo)
						sts_set[SB_CML] = 1'b1;
					else
						next_s.vcmd = hwdata[15:0];
				end
				ADR_TON: next_s.ton = hwdata[15:0];
				ADR_GAIN: next_s.gain = hwdata[7:0];
				ADR_MASK: next_s.mask = hwdata[5:0];
				ADR_STS: w1c = hwdata[5:0];
				default: ;
			endcase
		end

		// Recall deglitch: any high restarts the count
		if (s.sy[P_RECALL])
		begin
			next_s.rc_cnt = '0;
			next_s.rc_lo = 1'b0;
		end
		else if (s.rc_cnt != RC_TERM)
		begin
			next_s.rc_cnt = s.rc_cnt + 11'd1;
			next_s.rc_lo = (next_s.rc_cnt == RC_TERM);
		end
		// Qualified falling edge reloads the strap voltage; ramp follows
		if (next_s.rc_lo && !s.rc_lo)
		begin
			next_s.vcmd = s.vstrap;
			sts_set[SB_RECALL] = 1'b1;
		end

		// Supervisor
		case (s.st)
			ST_INIT:
			begin
				next_s.init_cnt = s.init_cnt + 21'd1;
				if (s.init_cnt == 21'(INIT_CYCLES - 1))
				begin
					// Straps are caught once; later changes are ignored
					next_s.vstrap = vs;
					next_s.vcmd = vs;
					next_s.ton = 16'(s.sy[19:16] + 5'd1) * 16'(SS_STEP_US);
					next_s.ph_strap = s.sy[22:20];
					next_s.ext = s.sy[P_EXT];
					next_s.master = s.sy[P_GND];
					next_s.st = ST_CHECK;
				end
			end
			ST_CHECK:
			begin
				if (s.sy[P_ADDR] || s.ph_strap == STRAP_BAD || s.vstrap > 16'(VOUT_MAX_MV))
				begin
					sts_set[SB_STRAP] = 1'b1;
					next_s.st = ST_FAULT;
				end
				else
					next_s.st = ST_OFF;
			end
			ST_OFF:
			begin
				next_s.setp = '0;
				next_s.step_cnt = '0;
				if (want_on)
				begin
					// Sense checked only before switching starts
					if (s.sy[P_SENSE])
						sts_set[SB_SENSE] = 1'b1;
					else
					begin
						next_s.st = ST_RAMP;
						next_s.sw_en = 1'b1;
					end
				end
			end
			ST_RAMP, ST_REG:
			begin
				if (!want_on)
				begin
					next_s.st = ST_OFF;
					next_s.sw_en = 1'b0;
				end
				else if (s.setp == s.vcmd)
				begin
					next_s.step_cnt = '0;
					next_s.st = ST_REG;
				end
				else if (s.step_cnt + 24'h00_0001 >= step_lim)
				begin
					// One millivolt per interval; interval set by ton and the target vcmd
					next_s.step_cnt = '0;
					next_s.setp = (s.setp < s.vcmd) ? s.setp + 16'h0001 : s.setp - 16'h0001;
				end
				else
					next_s.step_cnt = s.step_cnt + 24'h00_0001;
			end
			ST_FAULT: next_s.sw_en = 1'b0;
			default: next_s.st = ST_INIT;
		endcase

		// Power ok: settle delay, instant drop on low output
		if (s.st == ST_REG && s.setp == s.vcmd && !s.sy[P_LOW])
		begin
			if (s.pg_cnt != PG_TERM)
				next_s.pg_cnt = s.pg_cnt + 8'h01;
			next_s.pg_rel = (next_s.pg_cnt == PG_TERM);
		end
		else
		begin
			next_s.pg_cnt = '0;
			next_s.pg_rel = 1'b0;
		end
		if (s.pg_rel && !next_s.pg_rel)
			sts_set[SB_PG] = 1'b1;

		// Sync input qualification; master ignores its input
		next_s.sy_prev = s.sy[P_SYNC];
		if (s.master)
			next_s.sync_ok = 1'b0;
		else
		begin
			next_s.hi_cnt = s.sy[P_SYNC] ? ((s.hi_cnt == 10'h3FF) ? s.hi_cnt : s.hi_cnt + 10'h001) : '0;
			next_s.per_cnt = rise ? '0 : ((s.per_cnt == 10'h3FF) ? s.per_cnt : s.per_cnt + 10'h001);
			if (rise)
				next_s.sync_ok = s.per_cnt >= 10'(SYNC_PER_MIN) && s.per_cnt <= 10'(SYNC_PER_MAX);
			// Narrow pulse or lost signal disqualifies
			if ((fall && s.hi_cnt < 10'(SYNC_MIN_HI)) || s.per_cnt > 10'(SYNC_PER_MAX))
				next_s.sync_ok = 1'b0;
		end
		if (s.sync_ok && !next_s.sync_ok)
			sts_set[SB_SYNC] = 1'b1;

		// Timebase: realign on a good edge, else keep running
		if (!s.master && next_s.sync_ok && rise)
			next_s.ph_cnt = '0;
		else
			next_s.ph_cnt = (s.ph_cnt == 8'(SW_PER - 1)) ? '0 : s.ph_cnt + 8'h01;
		// Clock out for a star of downstream units, unless muted
		next_s.sync_out = (s.ph_strap != STRAP_NOCLK) && (next_s.ph_cnt < 8'(SW_PER / 2));
		for (int k = 0; k < 3; k++)
			next_s.sn[k] = s.sw_en && next_s.ph_cnt == pos[k] && (k < 2 || s.ext);
		next_s.ctrl = phase_current_rebalance;

		// Sticky status: a new event beats a clear
		next_s.sts = (s.sts & ~w1c) | sts_set;
		next_s.irq = |(next_s.sts & next_s.mask);

		// Address phase: latch, and fetch read data from updated state
		// Writes outside the low page are dropped, like reads
		next_s.a_wr = acc & hwrite & (haddr[31:8] == 24'h00_0000);
		next_s.a_addr = haddr[7:0];
		next_s.rdata = '0;
		if (acc && !hwrite && haddr[31:8] == 24'h00_0000)
		begin
			case (haddr[7:0])
				ADR_OPER: next_s.rdata = {24'h00_0000, next_s.oper};
				ADR_VOUT: next_s.rdata = {16'h0000, next_s.vcmd};
				ADR_TON: next_s.rdata = {16'h0000, next_s.ton};
				ADR_GAIN: next_s.rdata = {24'h00_0000, next_s.gain};
				ADR_STS: next_s.rdata = {26'h000_0000, next_s.sts};
				ADR_MASK: next_s.rdata = {26'h000_0000, next_s.mask};
				ADR_STATE: next_s.rdata = {7'h00, next_s.ph_strap, next_s.ext, next_s.master,
					next_s.sync_ok, next_s.rc_lo, next_s.sw_en, next_s.pg_rel, next_s.setp};
				default: next_s.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; enable low freezes everything
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s <= S_RST;
		else if (ce)
			s <= next_s;
	end

	// Outputs straight from flops
	assign hreadyout = s.rdy;
	assign hresp = s.resp;
	assign hrdata = s.rdata;
	assign sync_out = s.sync_out;
	assign power_ok_output_o = s.pg_o;
	assign power_ok_output_oe_n = s.pg_rel;
	assign switching_enable = s.sw_en;
	assign setpoint_mv = s.setp;
	assign switch_node_one = s.sn[0];
	assign switch_node_two = s.sn[1];
	assign switch_node_three = s.sn[2];
	assign phase_current_rebalance_one = s.ctrl[0];
	assign phase_current_rebalance_two = s.ctrl[1];
	assign phase_current_rebalance_three = s.ctrl[2];
	assign irq = s.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_recall_qualify: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(s.rc_lo) |-> s.rc_cnt == RC_TERM && !$past(s.sy[P_RECALL]))
		else $error("recall qualified early");
	chk_recall_restart: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && s.sy[P_RECALL]) |=> s.rc_cnt == 11'd0 && !s.rc_lo)
		else $error("deglitch did not restart");
	chk_recall_reload: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(s.rc_lo) |-> s.vcmd == s.vstrap)
		else $error("recall did not reload setpoint");
	chk_vout_refused: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && s.a_wr && s.a_addr == ADR_VOUT && s.rc_lo) |=> s.sts[SB_CML] && s.vcmd == $past(s.vcmd))
		else $error("setpoint write not refused");
	chk_oper_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && s.a_wr && s.a_addr == ADR_OPER && s.rc_lo && !oper_ok) |=> $stable(s.oper))
		else $error("operation change during recall");
	chk_pg_drop: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && s.sy[P_LOW]) |=> !s.pg_rel)
		else $error("power ok held on low output");
	chk_pg_delay: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(s.pg_rel) |-> s.pg_cnt == PG_TERM && $past(s.st) == ST_REG && $past(s.setp) == $past(s.vcmd))
		else $error("power ok before settle delay");
	chk_fault_block: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.st == ST_FAULT) |-> !s.sw_en ##1 !s.sw_en)
		else $error("switching with bad strap");
	chk_sense_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && s.st == ST_OFF && s.sy[P_SENSE]) |=> s.st == ST_OFF && !s.sw_en)
		else $error("started with sense open");
	chk_sync_mute: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.ph_strap == STRAP_NOCLK) |-> !s.sync_out)
		else $error("sync clock not muted");

endmodule : rssg_top

/* rssg_peer.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Peer unit acting as sync master in a star, free of the bench clock
module rssg_peer #(
	parameter realtime HALF_NS = 625.0
) (
	// Control and line
	input wire logic run,
	output logic sync_clk
);
	// Line rests low between bursts, the clock is optional
	initial sync_clk = 1'b0;

	// Toggle only while running; phase unrelated to hclk
	always
	begin
		#(HALF_NS);
		sync_clk = run ? ~sync_clk : 1'b0;
	end
endmodule : rssg_peer

/* rssg_top_test.sv */
`timescale 1ns/1ps
module rssg_top_test;
	import rssg_pkg::*;
	// Bench drives
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd = 0, recall_n = 1, sync_gnd = 1, sense_open = 0;
	logic below_pg = 0, en_pin = 0, strap_bad = 0, peer_run = 0, ce = 1, ext = 0;
	logic [2:0] strap_sync = 3'h0;
	// On/off codes still honoured while recall holds
	logic [7:0] m_codes [0:2] = '{OPER_OFF, OPER_SOFT, OPER_ON};
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, v;
	logic [15:0] common = 0;
	logic [11:0] cur1 = 0, cur2 = 0, cur3 = 0;
	// Design outputs and the peer sync clock
	wire logic hready, hresp, sync_in, sync_out, pg_o, oe_n, sw_en, sn1, sn2, sn3, irq;
	wire logic [31:0] hrdata;
	wire logic [15:0] setpoint, reb1, reb2, reb3;
	// Expected read data and masks, oldest first
	logic [31:0] q_exp[$], q_msk[$];
	int n_fail = 0, tests_run = 0, n, m;

	always #4 hclk = ~hclk;

	rssg_top #(.INIT_CYCLES(20)) rssg_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .recall_n(recall_n), .sync_in(sync_in),
		.sync_in_grounded(sync_gnd), .remote_sense_pos_open(sense_open), .vout_below_pg(below_pg),
		.enable_pin(en_pin), .addr_strap_bad(strap_bad), .ext_stage_present(ext),
		.vout_config_strap(8'h32), .softstart_config_strap(4'h0), .sync_strap(strap_sync), .sync_out(sync_out),
		.power_ok_output_o(pg_o), .power_ok_output_oe_n(oe_n), .switching_enable(sw_en), .setpoint_mv(setpoint),
		.switch_node_one(sn1), .switch_node_two(sn2), .switch_node_three(sn3), .common_ctrl(common),
		.phase_current_one(cur1), .phase_current_two(cur2), .phase_current_three(cur3),
		.phase_current_rebalance_one(reb1), .phase_current_rebalance_two(reb2),
		.phase_current_rebalance_three(reb3), .irq(irq));

	rssg_peer #(.HALF_NS(625.0)) rssg_peer_inst (.run(peer_run), .sync_clk(sync_in));

	////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	// Watched pins, by selector
	function automatic logic pin(input int s);
		case (s)
			0: return oe_n;
			1: return sn1;
			2: return sn2;
			3: return sync_out;
			4: return irq;
			5: return 1'(setpoint == 16'd1000);
			7: return sn3;
			default: return sync_in;
		endcase
	endfunction : pin

	// Bounded wait at falling edges, counts cycles taken
	task automatic wait_pin(input int s, input logic val, output int cnt);
		cnt = 0;
		do
		begin
			@(negedge hclk);
			cnt++;
		end
		while (pin(s) !== val && cnt < 5000);
		if (cnt >= 5000)
			chk(32'(s), 32'hFFFF);
	endtask : wait_pin

	// One single AHB-Lite transfer; reads leave a note for the monitor
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] msk);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0000_0000;
		rd <= ~w;
		if (!w)
		begin
			q_exp.push_back(d & msk);
			q_msk.push_back(msk);
		end
		do @(posedge hclk); while (hready !== 1'b1);
		rd <= 1'b0;
	endtask : bus

	// Monitor: read data is taken at the edge that ends the data phase
	always @(posedge hclk)
	begin
		if (rd && hready === 1'b1 && q_exp.size() > 0)
		begin
			chk(hrdata & q_msk.pop_front(), q_exp.pop_front());
			chk(hresp, 1'b0);
		end
	end

	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	// Watchdog, well beyond the roughly 6k cycles of the sequence
	initial
	begin
		#(8 * 60000);
		n_fail++;
		finish_test;
	end

	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(91));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (40) @(posedge hclk);
		// Reset values, strap loaded settings, unmapped hole
		bus(0, ADR_OPER, 32'h80, '1);
		bus(0, ADR_GAIN, 32'h04, '1);
		bus(0, ADR_MASK, 32'h00, '1);
		bus(0, 8'h40, 32'h00, '1);
		bus(0, ADR_VOUT, 32'd1000, '1);
		bus(0, ADR_TON, 32'd500, '1);
		// Open sense blocks the start
		sense_open <= 1'b1;
		en_pin <= 1'b1;
		bus(1, ADR_TON, 32'h1, 0);
		wait_pin(4, 1'b0, n);
		chk(sw_en, 1'b0);
		bus(0, ADR_STS, 32'h10, 32'h10);
		sense_open <= 1'b0;
		wait_pin(5, 1'b1, n);
		wait_pin(0, 1'b1, n);
		chk(32'(n >= 124 && n <= 128), 1);
		chk(pg_o, 1'b0);
		@(posedge hclk);
		sense_open <= 1'b1;
		repeat (20) @(negedge hclk);
		chk(sw_en, 1'b1);
		@(posedge hclk);
		sense_open <= 1'b0;
		bus(1, ADR_STS, 32'h3F, 0);
		// Master: own sync clock, high for the first half of its period
		wait_pin(3, 1'b0, n);
		wait_pin(3, 1'b1, n);
		wait_pin(3, 1'b0, n);
		wait_pin(3, 1'b1, m);
		chk(n + m, 156);
		chk(n, 78);
		wait_pin(1, 1'b1, n);
		wait_pin(2, 1'b1, n);
		chk(n, 78);
		// Follower with external stage: role and phases are caught at init only
		@(posedge hclk);
		sync_gnd <= 1'b0;
		ext <= 1'b1;
		peer_run <= 1'b1;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (40) @(posedge hclk);
		bus(1, ADR_TON, 32'h1, 0);
		repeat (800) @(posedge hclk);
		wait_pin(6, 1'b0, n);
		wait_pin(6, 1'b1, n);
		wait_pin(1, 1'b1, n);
		chk(32'(n >= 56 && n <= 61), 1);
		wait_pin(2, 1'b1, n);
		chk(n, 52);
		// A realigning edge may stretch count zero by one cycle
		wait_pin(7, 1'b1, n);
		chk(32'(n >= 52 && n <= 53), 1);
		// Peer clock lost: switching carries on
		bus(1, ADR_STS, 32'h3F, 0);
		peer_run <= 1'b0;
		repeat (400) @(negedge hclk);
		wait_pin(1, 1'b1, n);
		chk(sw_en, 1'b1);
		bus(0, ADR_STS, 32'h4, 32'h4);
		// Output below threshold, then interrupt masked, unmasked, cleared
		bus(1, ADR_STS, 32'h3F, 0);
		wait_pin(0, 1'b1, n);
		@(posedge hclk);
		below_pg <= 1'b1;
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		chk(oe_n, 1'b0);
		chk(irq, 1'b0);
		bus(1, ADR_MASK, 32'h2, 0);
		repeat (2) @(negedge hclk);
		chk(irq, 1'b1);
		below_pg <= 1'b0;
		bus(1, ADR_STS, 32'h2, 0);
		repeat (2) @(negedge hclk);
		chk(irq, 1'b0);
		// Rebalance: imbalance of -10 and +10 around the average
		@(posedge hclk);
		v = $urandom % 1000;
		common <= 16'h1000;
		cur1 <= v[11:0];
		cur2 <= v[11:0] + 12'd20;
		cur3 <= v[11:0] + 12'd10;
		repeat (2) @(negedge hclk);
		chk(reb1, 32'h1028);
		chk(reb2, 32'h0FD8);
		chk(reb3, 32'h1000);
		// Recall: a short low is ignored, a held low reloads the strap setpoint
		v = 32'd1100 + $urandom % 100;
		bus(1, ADR_VOUT, v, 0);
		bus(1, ADR_MASK, 32'h1, 0);
		repeat (300) @(posedge hclk);
		recall_n <= 1'b0;
		repeat (600) @(posedge hclk);
		recall_n <= 1'b1;
		repeat (20) @(negedge hclk);
		chk(irq, 1'b0);
		@(posedge hclk);
		recall_n <= 1'b0;
		wait_pin(4, 1'b1, n);
		chk(32'(n >= 1250 && n <= 1258), 1);
		chk(32'(setpoint > 16'd1000), 1);
		// Enable low: the ramp pauses where it stands
		@(posedge hclk);
		ce <= 1'b0;
		@(negedge hclk);
		v = 32'(setpoint);
		repeat (20) @(negedge hclk);
		chk(setpoint, v);
		@(posedge hclk);
		ce <= 1'b1;
		repeat (300) @(negedge hclk);
		chk(setpoint, 32'd1000);
		bus(0, ADR_STATE, 32'h4_0000, 32'h4_0000);
		bus(1, ADR_VOUT, 32'h500, 0);
		bus(0, ADR_VOUT, 32'd1000, '1);
		bus(0, ADR_STS, 32'h20, 32'h20);
		bus(1, ADR_OPER, 32'h55, 0);
		bus(0, ADR_OPER, 32'h80, '1);
		foreach (m_codes[i])
		begin
			bus(1, ADR_OPER, {24'h0, m_codes[i]}, 0);
			bus(0, ADR_OPER, {24'h0, m_codes[i]}, '1);
		end
		recall_n <= 1'b1;
		// Bad strap seen at init forbids switching; muting strap caught too
		@(posedge hclk);
		strap_bad <= 1'b1;
		strap_sync <= STRAP_NOCLK;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (60) @(negedge hclk);
		chk(sw_en, 1'b0);
		bus(0, ADR_STS, 32'h8, 32'h8);
		bus(0, ADR_STATE, 32'h0140_0000, 32'h01C0_0000);
		// Also lets the last read reach the monitor before the verdict
		m = 0;
		repeat (160) @(negedge hclk) m += int'(sync_out);
		chk(m, 0);
		finish_test;
	end

endmodule : rssg_top_test
